// ===== logic/pck_pkg.sv
// Purpose: Shared constants and types of the clock multiplier and lock block.
// Assumes: One 10 MHz system clock; APB registers, one word each.
// Notes:   Offsets are byte addresses on the register bus.
package pck_pkg;
  // ==========================================================
  // Sizes and register map
  localparam int          NLOOP       = 4;
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  STATUS_OFS  = 8'h00;
  localparam logic [7:0]  MASK_OFS    = 8'h04;
  localparam logic [7:0]  STATE_OFS   = 8'h08;
  localparam logic [7:0]  USERIO_OFS  = 8'h0c;
  localparam logic [7:0]  CFG_BASE    = 8'h10;
  localparam logic [7:0]  CTL_BASE    = 8'h14;
  localparam logic [7:0]  LOOP_STRIDE = 8'h08;
  // ==========================================================
  // Divider word fields
  localparam int CFG_M_LSB  = 0;
  localparam int CFG_N_LSB  = 8;
  localparam int CFG_K_LSB  = 16;
  localparam int CFG_V_LSB  = 24;
  localparam int CFG_ALT    = 29;
  // ==========================================================
  // Control word fields
  localparam int CTL_EN     = 0;
  localparam int CTL_FBEXT  = 1;
  localparam int CTL_PINOUT = 2;
  localparam int CTL_LCKPIN = 3;
  localparam int CTL_SERIAL = 4;
  localparam int CTL_SHARED = 5;
  localparam int CTL_PH_LSB = 8;
  localparam int CTL_DL_LSB = 12;
  localparam int CTL_EARLY  = 15;
  // ==========================================================
  // Reset values and limits
  localparam logic [31:0] CFG_RST    = 32'h0102_0102;
  localparam logic [31:0] CTL_RST    = 32'h0000_0000;
  localparam logic [11:0] MASK_RST   = 12'h000;
  localparam logic [7:0]  USERIO_RST = 8'hf0;
  localparam logic [7:0]  M_MIN      = 8'h02;
  localparam logic [7:0]  M_MAX      = 8'ha0;
  localparam logic [7:0]  N_MIN      = 8'h01;
  localparam logic [7:0]  N_MAX      = 8'h10;
  localparam logic [3:0]  DLY_MID    = 4'h8;
  // ==========================================================
  // Timing
  localparam int LOCK_TIME_NS  = 10000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int LOCK_CYC      = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int REF_GAP_CYC   = 64;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PCK_IDLE   = 2'b00,
    PCK_ACQ    = 2'b01,
    PCK_LOCKED = 2'b11
  } pck_lock_state_type;
  typedef enum logic [1:0] {
    PCK_X1  = 2'b00,
    PCK_X2  = 2'b01,
    PCK_X4  = 2'b10,
    PCK_XNA = 2'b11
  } pck_boost_type;
endpackage : pck_pkg

// ===== logic/pck_reg_if.sv
// Purpose: Register access path between the bus slave and the core.
// Assumes: Single clock domain.
// Notes:   wr is a one-cycle pulse at the completing bus edge.
`timescale 1ns/10ps
interface pck_reg_if;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;
  modport slave (output wr, output addr, output wdata, input rdata, input hit);
  modport core  (input wr, input addr, input wdata, output rdata, output hit);
endinterface : pck_reg_if

// ===== logic/pck_apb_slave.sv
// Purpose: APB slave with one wait state and registered answers.
// Assumes: Master holds the request until pready is seen high.
// Notes:   Unmapped or unaligned addresses answer with pslverr.
`timescale 1ns/10ps
module pck_apb_slave (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  pck_reg_if.slave         rif
);
  // ==========================================================
  // Access phase
  wire access = psel & penable;
  wire first  = access & ~pready;

  assign rif.addr  = paddr;
  assign rif.wdata = pwdata;
  // Writes land only at the edge where the master sees pready.
  assign rif.wr    = access & pready & pwrite & ~pslverr;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= first;
      if (first) begin
        prdata  <= pwrite ? 32'h0000_0000 : rif.rdata;
        pslverr <= ~rif.hit;
      end
    end
  end
endmodule : pck_apb_slave

// ===== logic/pck_loop.sv
// Purpose: One loop: lock detection, rate synthesis, phase and delay.
// Assumes: Reference and feedback are synchronous samples.
// Notes:   Output rate is capped at one tick per system clock.
`timescale 1ns/10ps
module pck_loop #(
  parameter int REF_GAP_CYC = pck_pkg::REF_GAP_CYC,
  parameter bit SERIAL_OK   = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       ref_in,
  input  wire logic       fb_in,
  input  wire logic       fb_ext,
  input  wire logic       serial,
  input  wire logic [7:0] mult,
  input  wire logic [4:0] pre_div,
  input  wire logic [7:0] post_div,
  input  wire logic [1:0] phase,
  input  wire logic [2:0] dly,
  input  wire logic       dly_early,
  output logic            gen_clk,
  output logic            tick_out,
  output logic            locked
);
  localparam logic [7:0] GAP  = 8'(REF_GAP_CYC);
  localparam logic [6:0] LAST = 7'(pck_pkg::LOCK_CYC - 1);
  pck_pkg::pck_lock_state_type st_r, st_nxt;
  logic        ref_d_r, fb_d_r, gen_d_r;
  logic [7:0]  rgap_r, fgap_r;
  logic [6:0]  acq_r;
  logic [15:0] acc_r;
  logic [1:0]  q_r;
  logic [15:0] sh_r;
  logic [3:0]  per_r, pcnt_r;
  // ==========================================================
  // Lock detection
  wire ref_edge = ref_in & ~ref_d_r;
  wire fb_edge  = fb_in & ~fb_d_r;
  wire good     = (rgap_r < GAP) & (~fb_ext | (fgap_r < GAP));
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      pck_pkg::PCK_IDLE:   if (run) st_nxt = pck_pkg::PCK_ACQ;
      pck_pkg::PCK_ACQ: begin
        if (!run) st_nxt = pck_pkg::PCK_IDLE;
        else if (good && acq_r == LAST) st_nxt = pck_pkg::PCK_LOCKED;
      end
      pck_pkg::PCK_LOCKED: begin
        if (!run) st_nxt = pck_pkg::PCK_IDLE;
        else if (!good) st_nxt = pck_pkg::PCK_ACQ;
      end
      default:             st_nxt = pck_pkg::PCK_IDLE;
    endcase
  end
  // ==========================================================
  // Rate synthesis: m/(n x post), four ticks per output period
  wire        nco_on = st_r != pck_pkg::PCK_IDLE;
  wire [15:0] thr    = 16'(pre_div * post_div);
  wire [15:0] sum    = acc_r + (ref_edge ? 16'({mult, 2'b00}) : 16'h0000);
  wire        tick   = nco_on & (sum >= thr);
  wire [1:0]  phq    = q_r - phase;
  wire        gen    = phq[1];
  wire [3:0]  d_eff  = ({1'b0, dly} > per_r) ? per_r : {1'b0, dly};
  wire [3:0]  tap    = dly_early ? pck_pkg::DLY_MID - d_eff : pck_pkg::DLY_MID + d_eff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= pck_pkg::PCK_IDLE;
      {ref_d_r, fb_d_r, gen_d_r} <= 3'b000;
      rgap_r <= 8'h00;
      fgap_r <= 8'h00;
      acq_r  <= 7'h00;
      acc_r  <= 16'h0000;
      q_r    <= 2'b00;
      sh_r   <= 16'h0000;
      per_r  <= 4'h0;
      pcnt_r <= 4'h0;
      {gen_clk, tick_out, locked} <= 3'b000;
    end else begin
      st_r    <= st_nxt;
      ref_d_r <= ref_in;
      fb_d_r  <= fb_in;
      gen_d_r <= gen;
      rgap_r  <= ref_edge ? 8'h00 : (rgap_r == 8'hff ? rgap_r : rgap_r + 8'h01);
      fgap_r  <= fb_edge ? 8'h00 : (fgap_r == 8'hff ? fgap_r : fgap_r + 8'h01);
      acq_r   <= (st_r == pck_pkg::PCK_ACQ && good) ? acq_r + 7'h01 : 7'h00;
      acc_r   <= !nco_on ? 16'h0000 : (tick ? sum - thr : sum);
      q_r     <= q_r + {1'b0, tick};
      sh_r    <= {sh_r[14:0], gen};
      pcnt_r  <= (gen & ~gen_d_r) ? 4'h1 : (pcnt_r == 4'hf ? pcnt_r : pcnt_r + 4'h1);
      if (gen & ~gen_d_r) per_r <= pcnt_r;
      gen_clk  <= sh_r[tap];
      tick_out <= SERIAL_OK & serial & tick;
      locked   <= st_nxt == pck_pkg::PCK_LOCKED;
    end
  end
endmodule : pck_loop

// ===== logic/pck_top.sv
// Purpose: Clock multiplier and lock management with an APB register file.
// Assumes: CONFIG_DONE marks the end of device configuration.
// Notes:   Loops 0 and 1 may drive serial capture clocks.
// Summary of operation
// - Loop 0 boost factor must not exceed loop 1; both x1, x2 or x4.
// - Shared input may feed loops 0 and 1; secondary input then unavailable.
// - Four independent loops; only loops 0 and 1 serve serial capture.
// - Output rate is input times m over n times post; ranges checked.
// - Output phase is selectable in ninety degree steps.
// - Output delay moves earlier or later by at most one output period.
// - Output may drive a pin; feedback may come from off chip.
// - Serial mode gives a capture clock at the serial bit rate.
// - Each loop raises its locked flag once locked to its reference.
// - An unused locked flag pin is returned to user input and output.
// - Reference is ignored until configuration is done, then lock starts.
// - Lock is reached once the reference has been good for ten microseconds.
`timescale 1ns/10ps
module pck_top (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  input  wire logic        CONFIG_DONE,
  input  wire logic        SHARED_CLOCK_INPUT,
  input  wire logic        SECONDARY_CLOCK_INPUT,
  input  wire logic [1:0]  GENERAL_CLOCK_INPUT,
  input  wire logic [3:0]  FEEDBACK_IN,
  output logic      [3:0]  GEN_CLK,
  output logic      [1:0]  CAPTURE_CLK,
  output logic      [3:0]  CLK_PIN_OUT,
  output logic      [3:0]  CLK_PIN_OE_N,
  input  wire logic [3:0]  LOCK_PIN_IN,
  output logic      [3:0]  LOCK_PIN_OUT,
  output logic      [3:0]  LOCK_PIN_OE_N
);
  localparam int N = pck_pkg::NLOOP;
  // ==========================================================
  // Decode helpers
  function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction : in_rng

  function automatic pck_pkg::pck_boost_type boost(input logic [7:0] m,
                                                   input logic [4:0] n,
                                                   input logic [7:0] p);
    logic [15:0] prod;
    prod = 16'(n * p);
    if ({8'h00, m} == prod)             boost = pck_pkg::PCK_X1;
    else if ({8'h00, m} == 16'(prod << 1)) boost = pck_pkg::PCK_X2;
    else if ({8'h00, m} == 16'(prod << 2)) boost = pck_pkg::PCK_X4;
    else                                boost = pck_pkg::PCK_XNA;
  endfunction : boost

  // ==========================================================
  // Register state
  pck_reg_if rif ();
  logic [31:0] cfg_r [N];
  logic [31:0] ctl_r [N];
  logic [11:0] status_r, mask_r;
  logic [7:0]  userio_r;
  logic [N-1:0] locked_d_r, bad_d_r;
  logic [N-1:0] pll_locked_flag;
  logic [N-1:0] gen_w;
  logic [1:0]   tick_w;
  logic [N-1:0] cfg_hit, ctl_hit;

  pck_apb_slave u_apb (
    .clk     (CLOCK),
    .rst_n   (RST_N),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .prdata  (PRDATA),
    .pready  (PREADY),
    .pslverr (PSLVERR),
    .rif     (rif)
  );

  // ==========================================================
  // Address decode
  wire st_hit = rif.addr == pck_pkg::STATUS_OFS;
  wire mk_hit = rif.addr == pck_pkg::MASK_OFS;
  wire sv_hit = rif.addr == pck_pkg::STATE_OFS;
  wire uo_hit = rif.addr == pck_pkg::USERIO_OFS;
  assign rif.hit = st_hit | mk_hit | sv_hit | uo_hit | (|cfg_hit) | (|ctl_hit);

  // ==========================================================
  // Per loop fields and checks
  logic [N-1:0] en, rng_ok, run, ref_sel;
  logic [7:0]   m_f [N];
  logic [4:0]   n_f [N];
  logic [7:0]   p_f [N];
  pck_pkg::pck_boost_type bc [N];

  for (genvar i = 0; i < N; i++) begin : g_dec
    wire [7:0] k_f = cfg_r[i][pck_pkg::CFG_K_LSB +: 8];
    wire [4:0] v_f = cfg_r[i][pck_pkg::CFG_V_LSB +: 5];
    assign cfg_hit[i] = rif.addr == 8'(pck_pkg::CFG_BASE + 8'(i) * pck_pkg::LOOP_STRIDE);
    assign ctl_hit[i] = rif.addr == 8'(pck_pkg::CTL_BASE + 8'(i) * pck_pkg::LOOP_STRIDE);
    assign m_f[i] = cfg_r[i][pck_pkg::CFG_M_LSB +: 8];
    assign n_f[i] = cfg_r[i][pck_pkg::CFG_N_LSB +: 5];
    assign p_f[i] = cfg_r[i][pck_pkg::CFG_ALT] ? {3'b000, v_f} : k_f;
    assign en[i]  = ctl_r[i][pck_pkg::CTL_EN];
    assign rng_ok[i] = in_rng(m_f[i], pck_pkg::M_MIN, pck_pkg::M_MAX)
                     & in_rng({3'b000, n_f[i]}, pck_pkg::N_MIN, pck_pkg::N_MAX)
                     & in_rng(k_f, pck_pkg::M_MIN, pck_pkg::M_MAX)
                     & in_rng({3'b000, v_f}, pck_pkg::N_MIN, pck_pkg::N_MAX);
    assign bc[i] = boost(m_f[i], n_f[i], p_f[i]);
  end

  // Loops 0 and 1 form the legacy pair; loop 0 must not out-boost loop 1.
  wire pair_on = en[0] & en[1];
  wire pair_ok = ~pair_on | ((bc[0] != pck_pkg::PCK_XNA) & (bc[1] != pck_pkg::PCK_XNA)
                 & (bc[0] <= bc[1]));
  wire [N-1:0] ok = rng_ok & {2'b11, pair_ok, pair_ok};
  assign run = {N{CONFIG_DONE}} & en & ok;
  wire [N-1:0] bad = en & ~ok;

  // With loop 0 taking the shared input, the secondary input is cut off.
  wire sec_block = ctl_r[0][pck_pkg::CTL_SHARED];
  wire sec_ref   = SECONDARY_CLOCK_INPUT & ~sec_block;
  assign ref_sel = {GENERAL_CLOCK_INPUT, SHARED_CLOCK_INPUT,
                    sec_block ? SHARED_CLOCK_INPUT : sec_ref};

  // ==========================================================
  // Loops
  for (genvar i = 0; i < N; i++) begin : g_loop
    logic tk;
    pck_loop #(
      .REF_GAP_CYC (pck_pkg::REF_GAP_CYC),
      .SERIAL_OK   (i < 2)
    ) u_loop (
      .clk       (CLOCK),
      .rst_n     (RST_N),
      .run       (run[i]),
      .ref_in    (ref_sel[i]),
      .fb_in     (FEEDBACK_IN[i]),
      .fb_ext    (ctl_r[i][pck_pkg::CTL_FBEXT]),
      .serial    (ctl_r[i][pck_pkg::CTL_SERIAL]),
      .mult      (m_f[i]),
      .pre_div   (n_f[i]),
      .post_div  (p_f[i]),
      .phase     (ctl_r[i][pck_pkg::CTL_PH_LSB +: 2]),
      .dly       (ctl_r[i][pck_pkg::CTL_DL_LSB +: 3]),
      .dly_early (ctl_r[i][pck_pkg::CTL_EARLY]),
      .gen_clk   (gen_w[i]),
      .tick_out  (tk),
      .locked    (pll_locked_flag[i])
    );
    if (i < 2) begin : g_cap
      assign tick_w[i] = tk;
    end
  end

  // ==========================================================
  // Events and read mux
  wire [N-1:0] gain = pll_locked_flag & ~locked_d_r;
  wire [N-1:0] loss = ~pll_locked_flag & locked_d_r;
  wire [N-1:0] errv = bad & ~bad_d_r;
  wire [11:0]  ev   = {errv, loss, gain};
  wire [11:0]  clr  = (rif.wr & st_hit) ? rif.wdata[11:0] : 12'h000;

  always_comb begin
    rif.rdata = 32'h0000_0000;
    if (st_hit) rif.rdata = {20'h00000, status_r};
    if (mk_hit) rif.rdata = {20'h00000, mask_r};
    if (sv_hit) rif.rdata = {19'h00000, sec_block, LOCK_PIN_IN, ok, pll_locked_flag};
    if (uo_hit) rif.rdata = {24'h000000, userio_r};
    for (int i = 0; i < N; i++) begin
      if (cfg_hit[i]) rif.rdata = cfg_r[i];
      if (ctl_hit[i]) rif.rdata = ctl_r[i];
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      status_r   <= 12'h000;
      mask_r     <= pck_pkg::MASK_RST;
      userio_r   <= pck_pkg::USERIO_RST;
      locked_d_r <= '0;
      bad_d_r    <= '0;
    end else begin
      // A new event wins over a clear in the same cycle.
      status_r   <= (status_r & ~clr) | ev;
      locked_d_r <= pll_locked_flag;
      bad_d_r    <= bad;
      if (rif.wr & mk_hit) mask_r <= rif.wdata[11:0];
      if (rif.wr & uo_hit) userio_r <= rif.wdata[7:0];
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_cfg
    always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
        cfg_r[i] <= pck_pkg::CFG_RST;
        ctl_r[i] <= pck_pkg::CTL_RST;
      end else begin
        if (rif.wr & cfg_hit[i]) cfg_r[i] <= rif.wdata;
        if (rif.wr & ctl_hit[i]) ctl_r[i] <= rif.wdata;
      end
    end
  end

  // ==========================================================
  // Registered pins
  logic [N-1:0] pin_en, lck_en;
  for (genvar i = 0; i < N; i++) begin : g_pin
    assign pin_en[i] = ctl_r[i][pck_pkg::CTL_PINOUT];
    assign lck_en[i] = ctl_r[i][pck_pkg::CTL_LCKPIN];
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      IRQ           <= 1'b0;
      GEN_CLK       <= 4'h0;
      CAPTURE_CLK   <= 2'b00;
      CLK_PIN_OUT   <= 4'h0;
      CLK_PIN_OE_N  <= 4'hf;
      LOCK_PIN_OUT  <= 4'h0;
      LOCK_PIN_OE_N <= 4'hf;
    end else begin
      IRQ           <= |(status_r & mask_r);
      GEN_CLK       <= gen_w;
      CAPTURE_CLK   <= tick_w;
      CLK_PIN_OUT   <= gen_w & pin_en;
      CLK_PIN_OE_N  <= ~pin_en;
      LOCK_PIN_OUT  <= (pll_locked_flag & lck_en) | (userio_r[3:0] & ~lck_en);
      LOCK_PIN_OE_N <= (4'h0 & lck_en) | (userio_r[7:4] & ~lck_en);
    end
  end
endmodule : pck_top

// ===== dv/pck_top_props.sv
// Purpose: Port-level checks of the clock multiplier and lock block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Attached by bind from the bench top.
`timescale 1ns/10ps
module pck_top_props (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        IRQ,
  input wire logic        CONFIG_DONE,
  input wire logic [3:0]  GEN_CLK,
  input wire logic [1:0]  CAPTURE_CLK,
  input wire logic [3:0]  CLK_PIN_OE_N,
  input wire logic [3:0]  LOCK_PIN_OE_N
);
  // ==========================================================
  // Sequences
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence s_access;
    PSEL && $rose(PENABLE);
  endsequence
  sequence s_answer;
    !PREADY ##1 PREADY;
  endsequence
  // ==========================================================
  // Assertions
  reset_quiet_a: assert property (disable iff (1'b0) !RST_N |=> !PREADY && !IRQ
    && CLK_PIN_OE_N == 4'hf && LOCK_PIN_OE_N == 4'hf && CAPTURE_CLK == 2'h0)
    else $error("outputs not at reset values");
  ready_wait_a: assert property (s_access |-> s_answer)
    else $error("access phase length wrong");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  ready_req_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready without a request");
  rdata_hold_a: assert property (!(PSEL && PENABLE) |=> $stable(PRDATA) && $stable(PSLVERR))
    else $error("read answer changed between accesses");
  refuse_zero_a: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("refused read returned data");
  gate_capture_a: assert property (!CONFIG_DONE [*4] |-> CAPTURE_CLK == 2'h0)
    else $error("capture clock before configuration");
  gate_gen_a: assert property (!CONFIG_DONE [*4] |-> $stable(GEN_CLK))
    else $error("generated clock before configuration");
endmodule : pck_top_props

// ===== dv/pck_ref_src.sv
// Purpose: Board reference clock source for all loop inputs.
// Assumes: Half period counted in system clocks.
// Notes:   Stopped, the clock stands low so the loops see lost edges.
`timescale 1ns/10ps
module pck_ref_src #(
  parameter int HALF = 4
) (
  input  wire logic       clk,
  input  wire logic       run,
  output logic      [3:0] ref_clk
);
  int cnt = 0;
  initial ref_clk = 4'h0;
  // One trace fans to every clock input, so all inputs run at one rate.
  always @(posedge clk) begin
    if (!run) begin
      cnt     <= 0;
      ref_clk <= 4'h0;
    end else if (cnt == HALF - 1) begin
      cnt     <= 0;
      ref_clk <= ~ref_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : pck_ref_src

// ===== dv/tb_top.sv
// Purpose: Self-checking bench of the clock multiplier and lock block.
// Assumes: Reference edges every eight system clocks.
// Notes:   Lock and loss times are checked as cycle windows.
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        config_done = 1'b0;
  logic        src_run = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [3:0]  ref_clk;
  logic [3:0]  gen_clk;
  logic [1:0]  capture_clk;
  logic [3:0]  clk_pin_out;
  logic [3:0]  clk_pin_oe_n;
  logic [3:0]  lock_pin_out;
  logic [3:0]  lock_pin_oe_n;
  logic [3:0]  lock_pin_in;
  logic [31:0] q;
  logic        e;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          n;
  // ==========================================================
  // Clock, pins and instances
  always #50 clock = ~clock;
  // Released lock pins are pulled up on the board.
  assign lock_pin_in = lock_pin_oe_n | lock_pin_out;
  pck_ref_src src_u (.clk(clock), .run(src_run), .ref_clk(ref_clk));
  pck_top dut_u (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .CONFIG_DONE(config_done),
    .SHARED_CLOCK_INPUT(ref_clk[0]), .SECONDARY_CLOCK_INPUT(ref_clk[1]),
    .GENERAL_CLOCK_INPUT(ref_clk[3:2]), .FEEDBACK_IN(gen_clk), .GEN_CLK(gen_clk),
    .CAPTURE_CLK(capture_clk), .CLK_PIN_OUT(clk_pin_out), .CLK_PIN_OE_N(clk_pin_oe_n),
    .LOCK_PIN_IN(lock_pin_in), .LOCK_PIN_OUT(lock_pin_out), .LOCK_PIN_OE_N(lock_pin_oe_n));
  // ==========================================================
  // Tasks
  function automatic logic [7:0] cfg_a(input int i);
    return pck_pkg::CFG_BASE + 8'(i) * pck_pkg::LOOP_STRIDE;
  endfunction : cfg_a
  function automatic logic [7:0] ctl_a(input int i);
    return pck_pkg::CTL_BASE + 8'(i) * pck_pkg::LOOP_STRIDE;
  endfunction : ctl_a
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int v, input int lo, input int hi);
    samples_checked++;
    if (v < lo || v > hi) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask : chk_rng
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask : rdc
  task automatic wait_pin(input logic v);
    n = 0;
    while (lock_pin_out[2] !== v && n < 400) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_pin
  task automatic count_rise();
    logic p;
    p = gen_clk[2];
    n = 0;
    repeat (80) begin
      @(posedge clock);
      if (gen_clk[2] === 1'b1 && p === 1'b0) n++;
      chk({31'h0, clk_pin_out[2]}, {31'h0, gen_clk[2]});
      p = gen_clk[2];
    end
  endtask : count_rise
  // ==========================================================
  // Tests
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < pck_pkg::NLOOP; i++) begin
      rdc(cfg_a(i), ALL, pck_pkg::CFG_RST);
      rdc(ctl_a(i), ALL, pck_pkg::CTL_RST);
    end
    rdc(pck_pkg::MASK_OFS, ALL, 32'h0);
    rdc(pck_pkg::USERIO_OFS, ALL, 32'h0000_00f0);
    apb(1'b1, 8'h30, 32'h0000_0001);
    rdc(8'h30, ALL, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, ctl_a(2), 32'h0000_000d);
    apb(1'b1, pck_pkg::MASK_OFS, 32'h0000_0004);
    repeat (150) @(posedge clock);
    rdc(pck_pkg::STATE_OFS, 32'h0000_000f, 32'h0);
    config_done <= 1'b1;
    wait_pin(1'b1);
    chk_rng(n, pck_pkg::LOCK_CYC, pck_pkg::LOCK_CYC + 4);
    // The interrupt follows the lock pin by one more register stage.
    @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    chk({28'h0, clk_pin_oe_n}, 32'h0000_000b);
    rdc(pck_pkg::STATE_OFS, 32'h0000_0f0f, 32'h0000_0f04);
    rdc(pck_pkg::STATUS_OFS, 32'h0000_00ff, 32'h0000_0004);
    apb(1'b1, pck_pkg::STATUS_OFS, 32'h0000_0004);
    rdc(pck_pkg::STATUS_OFS, 32'h0000_00ff, 32'h0);
    chk({31'h0, irq}, 32'h0);
    count_rise();
    chk_rng(n, 9, 11);
    apb(1'b1, cfg_a(2), 32'h0102_0104);
    repeat (120) @(posedge clock);
    count_rise();
    chk_rng(n, 19, 21);
    src_run <= 1'b0;
    wait_pin(1'b0);
    chk_rng(n, pck_pkg::REF_GAP_CYC - 8, pck_pkg::REF_GAP_CYC + 6);
    rdc(pck_pkg::STATUS_OFS, 32'h0000_0040, 32'h0000_0040);
    src_run <= 1'b1;
    apb(1'b1, cfg_a(1), 32'h0102_01a1);
    apb(1'b1, ctl_a(1), 32'h0000_0001);
    rdc(pck_pkg::STATE_OFS, 32'h0000_0020, 32'h0);
    rdc(pck_pkg::STATUS_OFS, 32'h0000_0200, 32'h0000_0200);
    apb(1'b1, cfg_a(1), 32'h10a0_10a0);
    rdc(pck_pkg::STATE_OFS, 32'h0000_0020, 32'h0000_0020);
    apb(1'b1, cfg_a(1), pck_pkg::CFG_RST);
    apb(1'b1, cfg_a(0), 32'h0102_0104);
    apb(1'b1, ctl_a(0), 32'h0000_0021);
    rdc(pck_pkg::STATE_OFS, 32'h0000_1000, 32'h0000_1000);
    apb(1'b0, pck_pkg::STATE_OFS, 32'h0);
    chk({31'h0, q[5:4] === 2'b11}, 32'h0);
    apb(1'b1, cfg_a(0), pck_pkg::CFG_RST);
    apb(1'b1, cfg_a(1), 32'h0102_0104);
    rdc(pck_pkg::STATE_OFS, 32'h0000_0030, 32'h0000_0030);
    apb(1'b1, ctl_a(0), 32'h0000_0031);
    n = 0;
    repeat (80) begin
      @(posedge clock);
      if (capture_clk[0] === 1'b1) n++;
    end
    chk_rng(n, 36, 44);
    chk({31'h0, gen_clk[3]}, 32'h0);
    apb(1'b1, ctl_a(3), 32'h0000_0200);
    repeat (16) @(posedge clock);
    chk({31'h0, gen_clk[3]}, 32'h1);
    apb(1'b1, ctl_a(2), 32'h0000_0001);
    apb(1'b1, pck_pkg::USERIO_OFS, 32'h0000_000a);
    repeat (2) @(posedge clock);
    chk({24'h0, lock_pin_oe_n, lock_pin_out}, 32'h0000_000a);
    rdc(pck_pkg::STATE_OFS, 32'h0000_0f00, 32'h0000_0a00);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    final_report();
  end
endmodule : tb_top
bind pck_top pck_top_props props_u (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .IRQ(IRQ), .CONFIG_DONE(CONFIG_DONE), .GEN_CLK(GEN_CLK),
  .CAPTURE_CLK(CAPTURE_CLK), .CLK_PIN_OE_N(CLK_PIN_OE_N), .LOCK_PIN_OE_N(LOCK_PIN_OE_N));
